// ### hdl/touch_adc_serial_port.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: Host uses clock idle low, rising-edge sampling.
// RULE2: Host reads result as two 8-bit transfers.
// RULE3: Output changes on falling, host samples rising.
// RULE4: First read byte: eight result MSBs first.
// RULE5: Second byte: four low bits, four zeros.
// RULE6: Data output released when select goes high.
// RULE7: Host selects chip before shifting command bits.
// RULE8: Leading one command starts conversion, full power.
// RULE9: Busy falling edge marks result bits coming.
// RULE10: Sixteen rising edges carry result plus trailers.
// RULE11: Host raises select after reading result.
// RULE12: Command picks analog input; that input converts.
// RULE13: First one starts command; zeros before conversion.
// RULE14: Command fields: start, channel, resolution, config, power.
// RULE15: Bit two: one single-ended, zero differential.
// RULE16: Select high aborts conversion, enters power-down.
// RULE17: Command shifted MSB first on rising edges.

// ----------------------------------------------------------------------
// Serial command and readout port of the touch converter.
// ----------------------------------------------------------------------
module touch_adc_serial_port (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic chip_select_n,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic [11:0] conv_result,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic busy,
  output logic conv_start,
  output logic conv_abort,
  output logic full_power,
  output touch_adc_pkg::cmd_type cmd
);

  // Every assertion below runs on the core clock and rests in reset.
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Synchronised pin levels and edges.
  logic cs_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic din_lvl;

  // Sequencer and shift state.
  touch_adc_pkg::state_type state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [5:0] cmd_sr_r, cmd_sr_nxt;
  logic [15:0] frame_r, frame_nxt;
  logic [4:0] shown_r, shown_nxt;
  logic [11:0] result_r, result_nxt;

  // Output registers.
  logic dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic busy_r, busy_nxt;
  logic start_r, start_nxt;
  logic abort_r, abort_nxt;
  logic power_r, power_nxt;
  touch_adc_pkg::cmd_type cmd_r, cmd_nxt;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------

  // Chip select rests high, so its stages leave reset deselected.
  pin_sync #(.IDLE(1'b1)) u_cs (.core_clk(core_clk), .resetn(resetn),
    .pin(chip_select_n), .level(cs_lvl), .rise(), .fall());
  // Serial shift clock, sampled for its edges.
  pin_sync u_sclk (.core_clk(core_clk), .resetn(resetn),
    .pin(serial_shift_clock), .level(), .rise(sclk_rise), .fall(sclk_fall));
  // Serial data input, delayed equally with the clock.
  pin_sync u_din (.core_clk(core_clk), .resetn(resetn),
    .pin(serial_data_in), .level(din_lvl), .rise(), .fall());

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------

  // Computes the next command, conversion and readout state.
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    cmd_sr_nxt = cmd_sr_r;
    frame_nxt = frame_r;
    shown_nxt = shown_r;
    result_nxt = result_r;
    dout_nxt = dout_r;
    busy_nxt = busy_r;
    start_nxt = 1'b0;
    abort_nxt = 1'b0;
    power_nxt = power_r;
    cmd_nxt = cmd_r;
    // The output drives only while the chip is selected.
    oe_nxt = ~cs_lvl; // RULE6
    if (cs_lvl) begin
      // Deselect abandons everything and powers down.
      if (state_r != touch_adc_pkg::ST_WAIT) begin
        abort_nxt = 1'b1; // RULE16
      end
      state_nxt = touch_adc_pkg::ST_WAIT;
      power_nxt = 1'b0; // RULE16
      busy_nxt = 1'b0;
      dout_nxt = 1'b0;
      bit_cnt_nxt = touch_adc_pkg::CNT_RESET;
    end else begin
      case (state_r)
        touch_adc_pkg::ST_WAIT: begin
          // Zeros go out; the first one seen is the start bit.
          dout_nxt = 1'b0; // RULE13
          if (sclk_rise && din_lvl) begin
            state_nxt = touch_adc_pkg::ST_CMD; // RULE13
            bit_cnt_nxt = touch_adc_pkg::CNT_RESET;
          end
        end
        touch_adc_pkg::ST_CMD: begin
          // Remaining command bits enter MSB first on rising edges.
          if (sclk_rise) begin
            cmd_sr_nxt = {cmd_sr_r[4:0], din_lvl}; // RULE17
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(touch_adc_pkg::CMD_BITS - 2)) begin
              // Decode the fields and launch the conversion.
              cmd_nxt = touch_adc_pkg::cmd_type'(
                {cmd_sr_r, din_lvl}); // RULE14 RULE15
              start_nxt = 1'b1; // RULE8
              power_nxt = 1'b1; // RULE8
              state_nxt = touch_adc_pkg::ST_ACQ;
            end
          end
        end
        touch_adc_pkg::ST_ACQ: begin
          // Busy rises on the falling edge after the command.
          if (sclk_fall) begin
            busy_nxt = 1'b1;
            state_nxt = touch_adc_pkg::ST_CONV;
          end
        end
        touch_adc_pkg::ST_CONV: begin
          // Busy falls as the MSB appears on the output.
          if (sclk_fall) begin
            busy_nxt = 1'b0; // RULE9
            result_nxt = conv_result; // RULE12
            if (cmd_r.resolution_12) begin
              // Twelve bits then four trailing zeros.
              frame_nxt = {conv_result, 4'h0}; // RULE5
            end else begin
              // Eight bits then zeros.
              frame_nxt = {conv_result[11:4], 8'h00};
            end
            dout_nxt = conv_result[11]; // RULE4
            shown_nxt = 5'h01;
            bit_cnt_nxt = touch_adc_pkg::CNT_RESET;
            state_nxt = touch_adc_pkg::ST_SHIFT;
          end
        end
        touch_adc_pkg::ST_SHIFT: begin
          // Next bit goes out on each falling edge.
          if (sclk_fall) begin
            dout_nxt = frame_r[14]; // RULE3
            frame_nxt = {frame_r[14:0], 1'b0};
            shown_nxt = shown_r + 5'h01;
          end
          // Sixteen rising edges close the readout.
          if (sclk_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(touch_adc_pkg::FRAME_BITS - 1)) begin
              state_nxt = touch_adc_pkg::ST_WAIT; // RULE10
              // Programmed power mode after the conversion.
              power_nxt = cmd_r.power_mode_lo;
            end
          end
        end
        default: begin
          state_nxt = touch_adc_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // Registers the sequencer state.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= touch_adc_pkg::ST_WAIT;
      bit_cnt_r <= touch_adc_pkg::CNT_RESET;
      cmd_sr_r <= 6'h00;
      frame_r <= touch_adc_pkg::FRAME_RESET;
      shown_r <= touch_adc_pkg::SHOWN_RESET;
      result_r <= 12'h000;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      busy_r <= 1'b0;
      start_r <= 1'b0;
      abort_r <= 1'b0;
      power_r <= 1'b0;
      cmd_r <= touch_adc_pkg::CMD_RESET;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      cmd_sr_r <= cmd_sr_nxt;
      frame_r <= frame_nxt;
      shown_r <= shown_nxt;
      result_r <= result_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      busy_r <= busy_nxt;
      start_r <= start_nxt;
      abort_r <= abort_nxt;
      power_r <= power_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // Outputs come straight from their registers.
  assign serial_data_out = dout_r;
  assign serial_data_out_oe = oe_r;
  assign busy = busy_r;
  assign conv_start = start_r;
  assign conv_abort = abort_r;
  assign full_power = power_r;
  assign cmd = cmd_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  // Launch of a conversion.
  sequence s_launch;
    start_r;
  endsequence

  // Output released while deselected.
  property p_hiz;
    cs_lvl |=> !oe_r && !busy_r;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output not released"); // RULE6

  // Command entry needs a one on a rising edge.
  property p_start_bit;
    state_r == touch_adc_pkg::ST_CMD
      && $past(state_r) == touch_adc_pkg::ST_WAIT
      |-> $past(sclk_rise && din_lvl);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start"); // RULE13

  // Zeros leave the port while waiting.
  property p_idle_zero;
    state_r == touch_adc_pkg::ST_WAIT
      && $past(state_r) == touch_adc_pkg::ST_WAIT
      |-> !dout_r;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("not zero"); // RULE13

  // Launch brings full power and then busy, or a deselect, within sixteen core cycles.
  property p_launch;
    s_launch |-> power_r ##0 !busy_r ##[1:16] (busy_r || cs_lvl);
  endproperty
  a_launch: assert property (p_launch) else $error("no busy"); // RULE8

  // Falling busy shows the result MSB.
  property p_msb;
    $fell(busy_r) && !cs_lvl |-> dout_r == result_r[11] && shown_r == 5'h01;
  endproperty
  a_msb: assert property (p_msb) else $error("msb missing"); // RULE4

  // Busy falls only into the readout or on a deselect.
  property p_busy_fall;
    $fell(busy_r) |-> state_r == touch_adc_pkg::ST_SHIFT || $past(cs_lvl);
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("bad busy"); // RULE9

  // Trailing bits are zero.
  property p_trailing;
    state_r == touch_adc_pkg::ST_SHIFT
      && shown_r > 5'(touch_adc_pkg::RESULT_BITS) |-> !dout_r;
  endproperty
  a_trailing: assert property (p_trailing) else $error("bad trailer"); // RULE5

  // Data changes only after a falling edge, a deselect or the end.
  property p_dout_edge;
    $changed(dout_r) |-> $past(sclk_fall) || $past(cs_lvl)
      || state_r == touch_adc_pkg::ST_WAIT;
  endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("early"); // RULE3

  // Deselect during activity aborts and powers down.
  property p_abort;
    cs_lvl && state_r != touch_adc_pkg::ST_WAIT |=> abort_r && !power_r
      && state_r == touch_adc_pkg::ST_WAIT;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort"); // RULE16

endmodule : touch_adc_serial_port

// ### hdl/touch_adc_pkg.sv
// ----------------------------------------------------------------------
// Shared constants and types of the touch converter serial port.
// ----------------------------------------------------------------------
package touch_adc_pkg;

  // Length of a command byte, start bit included.
  localparam int CMD_BITS = 8;
  // Width of a full conversion result.
  localparam int RESULT_BITS = 12;
  // Width of a result in low resolution mode.
  localparam int LOW_RES_BITS = 8;
  // Number of bits read out after the busy indication.
  localparam int FRAME_BITS = 16;

  // Field positions within the seven bits that follow the start bit.
  localparam int POS_CHANNEL_2 = 6;
  localparam int POS_CHANNEL_1 = 5;
  localparam int POS_CHANNEL_0 = 4;
  localparam int POS_RESOLUTION = 3;
  localparam int POS_INPUT_CONFIG = 2;
  localparam int POS_POWER_HI = 1;
  localparam int POS_POWER_LO = 0;

  // Reset values of the control state.
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [4:0] SHOWN_RESET = 5'h00;
  localparam logic [15:0] FRAME_RESET = 16'h0000;

  // Decoded command byte.
  typedef struct packed {
    logic channel_addr_2;
    logic channel_addr_1;
    logic channel_addr_0;
    logic resolution_12;
    logic input_config_select;
    logic power_mode_hi;
    logic power_mode_lo;
  } cmd_type;

  // Reset value of the decoded command.
  localparam cmd_type CMD_RESET = 7'h00;

  // Sequencer states, Gray coded along the path from ST_WAIT to ST_SHIFT.
  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_CMD = 3'h1,
    ST_ACQ = 3'h3,
    ST_CONV = 3'h2,
    ST_SHIFT = 3'h6
  } state_type;

endpackage : touch_adc_pkg

// ### hdl/pin_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Two-stage synchroniser with edge detection on the synchronised level.
// ----------------------------------------------------------------------
module pin_sync #(
  // Resting level of the pin, loaded at reset so no false edge follows.
  parameter logic IDLE = 1'b0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  // The first stage is only read by the second stage.
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Registers the pin through two stages and keeps one older copy.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
      prev_r <= IDLE;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Level and edges come only from the settled stages.
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule : pin_sync

// ### sim/host_model.sv
`timescale 1ns/1ps
// ----
// Host serial port model, clock idle low, data taken on the rise.
// ----
module host_model (
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  input wire logic busy
);
  // Half of the 800 ns link period.
  localparam int HALF = 400;

  // The link rests deselected with its clock low.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // One link clock: bit set while low, busy and data taken at the rise.
  task automatic tick(input logic b, output logic [1:0] q);
    mosi = b;
    #HALF;
    q = {busy, miso};
    sclk = 1'b1;
    #HALF;
    sclk = 1'b0;
  endtask : tick

  // Zeros, command byte, a spare clock, then two read bytes.
  task automatic convert(input logic [7:0] c, input int lead,
    input bit full, output logic [15:0] rd, output logic [1:0] bz,
    output logic pre);
    logic [1:0] q;
    pre = 1'b0;
    rd = 16'h0000;
    bz = 2'b00;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < lead; i++) begin
      tick(1'b0, q);
      pre = pre | q[0];
    end
    for (int i = 7; i >= 0; i--) begin
      tick(c[i], q);
    end
    if (full) begin
      tick(1'b0, q);
      bz[1] = q[1];
      for (int i = 15; i >= 0; i--) begin
        tick(1'b0, q);
        rd[i] = q[0];
        if (i == 15) begin
          bz[0] = q[1];
        end
      end
    end
    #HALF;
    cs_n = 1'b1;
  endtask : convert
endmodule : host_model

// ### sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
// ----
// Self-checking bench of the touch converter serial port.
// ----
module tb_top;
  logic core_clk; // System clock.
  logic resetn; // Active low reset.
  logic [11:0] conv_result; // Value the converter offers.
  logic cs_n;
  logic sclk;
  logic mosi;
  logic dout;
  logic oe;
  logic busy;
  logic conv_start;
  logic conv_abort;
  logic full_power;
  touch_adc_pkg::cmd_type cmd;
  wire miso; // Data line seen by the host; inverted when released.
  logic [15:0] rd;
  logic [1:0] bz;
  logic pre;
  logic [7:0] c;
  int errors = 0;
  int tests_run = 0;
  int starts = 0; // Conversion start pulses seen.
  int aborts = 0; // Abort pulses seen.
  int exq[$]; // Expected read frames, oldest first.

  assign miso = oe ? dout : ~dout;

  touch_adc_serial_port DUT (.core_clk(core_clk), .resetn(resetn),
    .chip_select_n(cs_n), .serial_shift_clock(sclk),
    .serial_data_in(mosi), .conv_result(conv_result),
    .serial_data_out(dout), .serial_data_out_oe(oe), .busy(busy),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .full_power(full_power), .cmd(cmd));

  host_model u_host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .busy(busy));

  // Clock of 100 ns period.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Counts pulses mid-cycle, where outputs are settled; while busy the
  // device must be powered and driving.
  always @(negedge core_clk) begin
    if (conv_start === 1'b1) starts++;
    if (conv_abort === 1'b1) aborts++;
    if (busy === 1'b1) `CHK({full_power, oe}, 2'b11)
  end

  // Frame the host reads: 12 bits then zeros, or 8 bits then zeros.
  function automatic int exp_frame(int r, bit m);
    return m ? (r << 4) : ((r >> 4) << 8);
  endfunction : exp_frame

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // Main sequence: every channel and power code, then an abort.
  initial begin
    resetn = 1'b0;
    conv_result = 12'h000;
    void'($urandom(32'h05f870f7));
    repeat (8) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1;
      c = {1'b1, i[2:0], i[1] ^ i[2], 1'($urandom()), i[1:0]};
      conv_result = 12'($urandom());
      exq.push_back(exp_frame(conv_result, c[3]));
      u_host.convert(c, i % 3, 1'b1, rd, bz, pre);
      `CHK(pre, 1'b0)
      `CHK(bz, 2'b10)
      `CHK(rd, 16'(exq.pop_front()))
      `CHK(cmd, c[6:0])
      `CHK(full_power, c[0])
      repeat (5) @(posedge core_clk);
      #1;
      `CHK({oe, full_power}, 2'b00)
    end
    `CHK(starts, 8)
    `CHK(aborts, 0)
    // Deselect while busy, after the falling edge that follows the command and before any readout.
    u_host.convert(8'h9d, 1, 1'b0, rd, bz, pre);
    repeat (5) @(posedge core_clk);
    #1;
    `CHK(aborts, 1)
    `CHK({oe, full_power}, 2'b00)
    `CHK(starts, 9)
    results();
  end

  // Watchdog: the tests need some 1900 cycles, this allows 20000.
  initial begin
    #2000000;
    errors++;
    results();
  end
endmodule : tb_top
